// [fuse_prog_pkg.sv]
// Constants shared by the supply-pulse fuse programmer.
package fuse_prog_pkg;
  localparam int CLK_MHZ = 25;
  // Least on-time of enable, address and lock pulses, in microseconds.
  localparam int PULSE_MIN_US = 20;
  // Least on-time of a fuse-blowing pulse, in microseconds.
  localparam int FUSE_PULSE_MIN_US = 100;
  localparam int PULSE_MIN_CYC = PULSE_MIN_US * CLK_MHZ;
  localparam int FUSE_PULSE_MIN_CYC = FUSE_PULSE_MIN_US * CLK_MHZ;
  localparam int TIMER_W = 13;
  localparam logic [TIMER_W-1:0] PULSE_MIN_CNT = TIMER_W'(PULSE_MIN_CYC);
  localparam logic [TIMER_W-1:0] FUSE_MIN_CNT = TIMER_W'(FUSE_PULSE_MIN_CYC);
  localparam int CODE_W = 7;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] LOCK_ADDR = 8'h80;
  localparam logic [ADDR_W-1:0] ADDR_LAST = 8'h80;
  localparam int PROG_KEY_MID_MIN = 7;
  localparam int POL_KEY_MID_MIN = 1;
  localparam int POL_KEY_MID_MAX = 6;
  localparam int MID_CNT_W = 4;
  localparam logic [MID_CNT_W-1:0] MID_CNT_SAT = 4'hF;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_KEY_MID = 3'b001,
    ST_ADDR = 3'b010,
    ST_PEN_MID = 3'b011,
    ST_ARMED = 3'b100
  } prog_state_t;
  typedef enum logic [1:0] {
    LVL_NONE = 2'b00,
    LVL_MID = 2'b01,
    LVL_TOP = 2'b10
  } pulse_lvl_t;
endpackage : fuse_prog_pkg

// [pulse_classifier.sv]
// Synchronises the supply comparators and reports each finished pulse with its level and width.
`timescale 1ns/1ps
module pulse_classifier (
  input wire logic MCLK_I,
  input wire logic ARST_N_I,
  input wire logic mid_i,
  input wire logic top_i,
  output logic done_o,
  output fuse_prog_pkg::pulse_lvl_t lvl_o,
  output logic long_o,
  output logic short_o
);
  import fuse_prog_pkg::*;
  logic [1:0] mid_sync;
  logic [1:0] top_sync;
  logic seen_top;
  logic high;
  logic [TIMER_W-1:0] width;
  wire mid_now = mid_sync[1];
  wire top_now = top_sync[1];
  wire falling = high && !mid_now;
  wire [TIMER_W-1:0] width_inc = (width == {TIMER_W{1'b1}}) ? width : width + 1'b1;

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      mid_sync <= 2'b00;
      top_sync <= 2'b00;
      high <= 1'b0;
      seen_top <= 1'b0;
      width <= '0;
      done_o <= 1'b0;
      lvl_o <= LVL_NONE;
      long_o <= 1'b0;
      short_o <= 1'b0;
    end else begin
      mid_sync <= {mid_sync[0], mid_i};
      top_sync <= {top_sync[0], top_i};
      high <= mid_now;
      width <= mid_now ? width_inc : '0;
      seen_top <= mid_now ? (seen_top | top_now) : 1'b0;
      done_o <= falling;
      lvl_o <= falling ? (seen_top ? LVL_TOP : LVL_MID) : LVL_NONE;
      long_o <= falling && (width >= FUSE_MIN_CNT);
      short_o <= falling && (width < PULSE_MIN_CNT);
    end
  end
endmodule : pulse_classifier

// [supply_pulse_fuse_programmer.sv]
// Decodes supply-pulse keys and addresses and blows code, polarity and lock fuses.
//
// Overview of operation
// - Program key: top pulse, seven or more mid pulses, top pulse, no dropout.
// - Addressed code bit plus long top pulse blows that fuse for good.
// - Polarity fuse blown by final long top pulse; stays set.
// - Polarity fuse shifts range negative only, output sense unchanged.
// - Address 128 selects lock fuse; once blown, all programming refused.
// - Addresses step one per pulse; first is top, later ones mid.
// - Polarity key: top pulse then one to six mid pulses.
`timescale 1ns/1ps
module supply_pulse_fuse_programmer (
  input wire logic MCLK_I,
  input wire logic ARST_N_I,
  input wire logic SUPPLY_OK_I,
  input wire logic MID_LEVEL_I,
  input wire logic TOP_LEVEL_I,
  input wire logic [fuse_prog_pkg::CODE_W-1:0] FUSE_CODE_I,
  input wire logic FUSE_POL_I,
  input wire logic FUSE_LOCK_I,
  output logic [fuse_prog_pkg::CODE_W-1:0] TRIAL_CODE_O,
  output logic NEG_RANGE_O,
  output logic PROG_EN_O,
  output logic BLOW_O,
  output logic [fuse_prog_pkg::ADDR_W-1:0] BLOW_SEL_O,
  output logic BLOW_POL_O,
  output logic LOCKED_O
);
  import fuse_prog_pkg::*;

  // Supply presence comes from an analog monitor, so it is synchronised too.
  logic [1:0] supply_sync;
  wire supply_ok = supply_sync[1];
  logic pdone;
  pulse_lvl_t plvl;
  logic plong;
  logic pshort;

  pulse_classifier u_cls (
    .MCLK_I(MCLK_I),
    .ARST_N_I(ARST_N_I),
    .mid_i(MID_LEVEL_I),
    .top_i(TOP_LEVEL_I),
    .done_o(pdone),
    .lvl_o(plvl),
    .long_o(plong),
    .short_o(pshort)
  );

  prog_state_t state;
  prog_state_t next_state;
  logic [MID_CNT_W-1:0] mid_cnt;
  logic [ADDR_W-1:0] addr;
  logic neg_key;
  logic pol_key_ok;
  logic [1:0] fuse_sync_stage;
  logic lock_fuse;

  // The lock fuse is a static level that is still resynchronised because it may settle late.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      supply_sync <= 2'b00;
      fuse_sync_stage <= 2'b00;
      lock_fuse <= 1'b0;
    end else begin
      supply_sync <= {supply_sync[0], SUPPLY_OK_I};
      fuse_sync_stage <= {fuse_sync_stage[0], FUSE_LOCK_I};
      lock_fuse <= fuse_sync_stage[1];
    end
  end

  wire locked = lock_fuse || LOCKED_O;
  wire p_top = pdone && (plvl == LVL_TOP) && !pshort;
  wire p_mid = pdone && (plvl == LVL_MID) && !pshort;
  wire p_bad = pdone && pshort;
  wire [MID_CNT_W-1:0] mid_inc = (mid_cnt == MID_CNT_SAT) ? mid_cnt : mid_cnt + 1'b1;
  wire key_is_prog = mid_cnt >= MID_CNT_W'(PROG_KEY_MID_MIN);
  wire key_is_pol = (mid_cnt >= MID_CNT_W'(POL_KEY_MID_MIN))
                 && (mid_cnt <= MID_CNT_W'(POL_KEY_MID_MAX));
  wire [ADDR_W-1:0] addr_inc = (addr == ADDR_LAST) ? addr : addr + 1'b1;
  wire [ADDR_W-1:0] neg_addr = {{(ADDR_W - MID_CNT_W){1'b0}}, mid_cnt};
  wire open_run = (next_state == ST_KEY_MID) && (state != ST_KEY_MID);
  wire neg_resolve = (state == ST_ADDR) && (next_state == ST_PEN_MID);
  // A blow needs a long top pulse after an armed key; short pulses never burn a fuse.
  wire blow_now = (state == ST_ARMED) && p_top && plong && !locked;
  wire [CODE_W-1:0] code_now = addr[CODE_W-1:0];

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (p_top) begin
          next_state = ST_KEY_MID;
        end
      end
      // The first run after an opening top steps the positive address.
      ST_KEY_MID: begin
        if (p_top && key_is_pol) begin
          next_state = ST_ADDR;
        end else if (p_top) begin
          next_state = ST_PEN_MID;
        end
      end
      // A short first run is a positive address or a polarity key; the next run decides.
      // Negative addresses therefore stop at six, as a longer run reads as a program key.
      ST_ADDR: begin
        if (p_top && key_is_prog && !locked) begin
          next_state = ST_ARMED;
        end else if (p_top && !key_is_prog) begin
          next_state = ST_PEN_MID;
        end else if (p_top) begin
          next_state = ST_IDLE;
        end
      end
      ST_PEN_MID: begin
        if (p_top && key_is_prog && !locked) begin
          next_state = ST_ARMED;
        end else if (p_top) begin
          next_state = ST_KEY_MID;
        end
      end
      ST_ARMED: begin
        if (p_top) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (p_bad || !supply_ok) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state <= ST_IDLE;
      mid_cnt <= '0;
      addr <= '0;
      neg_key <= 1'b0;
      pol_key_ok <= 1'b0;
    end else if (!supply_ok) begin
      state <= ST_IDLE;
      mid_cnt <= '0;
      addr <= '0;
      neg_key <= 1'b0;
      pol_key_ok <= 1'b0;
    end else begin
      state <= next_state;
      if (p_top) begin
        mid_cnt <= '0;
      end else if (p_mid) begin
        mid_cnt <= mid_inc;
      end
      // An opening top is address 0 and drops any earlier polarity key.
      if (open_run) begin
        addr <= '0;
        neg_key <= 1'b0;
        pol_key_ok <= 1'b0;
      end else if (state == ST_KEY_MID && p_mid) begin
        addr <= addr_inc;
      end else if (neg_resolve) begin
        addr <= neg_addr;
        neg_key <= 1'b1;
        pol_key_ok <= 1'b1;
      end
    end
  end

  // Output register group: all outputs come straight from flip-flops.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      TRIAL_CODE_O <= '0;
      NEG_RANGE_O <= 1'b0;
      PROG_EN_O <= 1'b0;
      BLOW_O <= 1'b0;
      BLOW_SEL_O <= '0;
      BLOW_POL_O <= 1'b0;
      LOCKED_O <= 1'b0;
    end else begin
      // Polarity only moves the trim range; the switch output sense is never touched here.
      TRIAL_CODE_O <= FUSE_CODE_I | code_now;
      NEG_RANGE_O <= FUSE_POL_I | (supply_ok & neg_key);
      PROG_EN_O <= supply_ok && (next_state == ST_ARMED);
      BLOW_O <= supply_ok && blow_now;
      // The polarity key with no address run blows the polarity fuse instead of a code bit.
      BLOW_POL_O <= supply_ok && blow_now && pol_key_ok && (addr == '0);
      if (blow_now) begin
        BLOW_SEL_O <= addr;
      end
      if (blow_now && addr == LOCK_ADDR) begin
        LOCKED_O <= 1'b1;
      end else if (lock_fuse) begin
        LOCKED_O <= 1'b1;
      end
    end
  end

  chk_lock_refuses: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    LOCKED_O |=> !PROG_EN_O && !BLOW_O)
    else $error("Programming enabled while locked.");

  chk_lock_sticks: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    LOCKED_O |=> LOCKED_O)
    else $error("Lock state was lost.");

  chk_blow_needs_arm: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    BLOW_O |-> $past(PROG_EN_O))
    else $error("Fuse blown without armed program key.");

  chk_supply_clears: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    !supply_ok |=> state == ST_IDLE && addr == '0 && mid_cnt == '0)
    else $error("Supply loss did not clear key state.");

  chk_arm_key_mid: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    (state != ST_ARMED) && (next_state == ST_ARMED) |-> mid_cnt >= 4'h7 && p_top)
    else $error("Program mode armed without seven mid pulses.");

  sequence s_blow_seen;
    BLOW_O ##1 !BLOW_O;
  endsequence

  chk_blow_single: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    BLOW_O |-> s_blow_seen)
    else $error("Blow strobe wider than one cycle.");

  chk_pol_blow: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    BLOW_POL_O |-> BLOW_O && BLOW_SEL_O == 8'h00)
    else $error("Polarity blow without blow strobe.");

  chk_addr_range: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    addr <= 8'h80)
    else $error("Address passed the lock position.");

  chk_pol_key_len: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    $rose(state == ST_ADDR) |-> $past(mid_cnt) >= 4'h1 && $past(mid_cnt) <= 4'h6)
    else $error("Polarity key length out of range.");

  chk_neg_sticky: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    FUSE_POL_I |=> NEG_RANGE_O)
    else $error("Blown polarity fuse not shown in range.");
endmodule : supply_pulse_fuse_programmer

// [supply_pulser.sv]
// Behavioural programmer that sends raised-level pulses on the supply pin.
`timescale 1ns/1ps
module supply_pulser (
  input wire logic clk_i,
  output logic mid_o,
  output logic top_o,
  output logic ok_o
);
  localparam int GAP_CYC = 520;
  initial begin
    mid_o = 1'b0;
    top_o = 1'b0;
    ok_o = 1'b1;
  end
  // The mid comparator also trips during a top pulse, so both rise together.
  task automatic pulse(input logic top, input int hi);
    @(negedge clk_i);
    mid_o = 1'b1;
    top_o = top;
    repeat (hi) @(negedge clk_i);
    mid_o = 1'b0;
    top_o = 1'b0;
    repeat (GAP_CYC) @(negedge clk_i);
  endtask : pulse
  // Opening top pulse, a run of mid pulses, closing top pulse.
  task automatic key(input int mids);
    pulse(1'b1, 520);
    repeat (mids) pulse(1'b0, 520);
    pulse(1'b1, 520);
  endtask : key
  task automatic dropout();
    @(negedge clk_i);
    ok_o = 1'b0;
    repeat (10) @(negedge clk_i);
    ok_o = 1'b1;
  endtask : dropout
endmodule : supply_pulser

// [tb.sv]
// Self-checking bench for the supply-pulse fuse programmer.
`timescale 1ns/1ps
module tb;
  import fuse_prog_pkg::*;
  logic mclk, arst_n, mid, top, ok, fuse_pol, fuse_lock;
  logic neg_range, prog_en, blow, blow_pol, locked, last_pol;
  logic [CODE_W-1:0] fuse_code, trial_code;
  logic [ADDR_W-1:0] blow_sel, last_sel;
  int bad_count = 0;
  int cmp_count = 0;
  int blow_cnt = 0;
  int n;
  supply_pulser u_prog (.clk_i(mclk), .mid_o(mid), .top_o(top), .ok_o(ok));
  supply_pulse_fuse_programmer u_dut (.MCLK_I(mclk), .ARST_N_I(arst_n), .SUPPLY_OK_I(ok),
    .MID_LEVEL_I(mid), .TOP_LEVEL_I(top), .FUSE_CODE_I(fuse_code), .FUSE_POL_I(fuse_pol),
    .FUSE_LOCK_I(fuse_lock), .TRIAL_CODE_O(trial_code), .NEG_RANGE_O(neg_range),
    .PROG_EN_O(prog_en), .BLOW_O(blow), .BLOW_SEL_O(blow_sel), .BLOW_POL_O(blow_pol),
    .LOCKED_O(locked));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // A blow strobe that stood longer than one cycle would be counted twice.
  always @(negedge mclk) begin
    if (blow === 1'b1) begin
      blow_cnt++;
      last_sel = blow_sel;
      last_pol = blow_pol;
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize
  task automatic rst();
    arst_n = 1'b0;
    repeat (20) @(negedge mclk);
    arst_n = 1'b1;
    repeat (5) @(negedge mclk);
  endtask : rst
  task automatic s_code();
    rst();
    fuse_code = 7'h04;
    u_prog.pulse(1'b1, 520);
    u_prog.pulse(1'b0, 520);
    check(8'(trial_code), 8'h05);
    u_prog.key(7);
    check(8'(prog_en), 8'h01);
    check(8'(neg_range), 8'h00);
    n = blow_cnt;
    u_prog.pulse(1'b1, 2600);
    check(8'(blow_cnt - n), 8'h01);
    check(last_sel, 8'h01);
    check(8'(last_pol), 8'h00);
    check(8'(prog_en), 8'h00);
  endtask : s_code
  task automatic s_short_key();
    rst();
    u_prog.pulse(1'b1, 520);
    u_prog.key(6);
    check(8'(prog_en), 8'h00);
    u_prog.key(7);
    check(8'(prog_en), 8'h01);
    n = blow_cnt;
    u_prog.pulse(1'b1, 100);
    check(8'(prog_en), 8'h00);
    check(8'(blow_cnt - n), 8'h00);
  endtask : s_short_key
  task automatic s_dropout();
    rst();
    fuse_code = 7'h00;
    u_prog.pulse(1'b1, 520);
    u_prog.pulse(1'b0, 520);
    u_prog.pulse(1'b1, 520);
    repeat (4) u_prog.pulse(1'b0, 520);
    u_prog.dropout();
    check(8'(trial_code), 8'h00);
    repeat (3) u_prog.pulse(1'b0, 520);
    u_prog.pulse(1'b1, 520);
    check(8'(prog_en), 8'h00);
  endtask : s_dropout
  task automatic s_polarity();
    rst();
    u_prog.pulse(1'b1, 520);
    repeat (2) u_prog.pulse(1'b0, 520);
    u_prog.pulse(1'b1, 520);
    u_prog.key(7);
    check(8'(neg_range), 8'h01);
    check(8'(prog_en), 8'h01);
    n = blow_cnt;
    u_prog.pulse(1'b1, 2600);
    check(8'(blow_cnt - n), 8'h01);
    check(8'(last_pol), 8'h01);
    check(last_sel, 8'h00);
    fuse_pol = 1'b1;
    rst();
    check(8'(neg_range), 8'h01);
  endtask : s_polarity
  task automatic s_lock();
    fuse_lock = 1'b1;
    rst();
    repeat (10) @(negedge mclk);
    check(8'(locked), 8'h01);
    u_prog.pulse(1'b1, 520);
    u_prog.key(7);
    check(8'(prog_en), 8'h00);
    n = blow_cnt;
    u_prog.pulse(1'b1, 2600);
    check(8'(blow_cnt - n), 8'h00);
    check(8'(locked), 8'h01);
  endtask : s_lock
  initial begin
    arst_n = 1'b0;
    fuse_code = 7'h00;
    fuse_pol = 1'b0;
    fuse_lock = 1'b0;
    s_code();
    s_short_key();
    s_dropout();
    s_polarity();
    s_lock();
    summarize();
  end
  // A hang anywhere is cut short here and counted as a mismatch.
  initial begin
    repeat (90000) @(posedge mclk);
    bad_count++;
    summarize();
  end
endmodule : tb
